// >>> logic/irq_control_unit.sv
// Purpose: Cascaded master and slave interrupt controller pair.
// Assumes: Core acknowledge and commands arrive on clk.
// Notes:   Vector is the base times eight plus the input.
`include "irq_params.svh"
module irq_control_unit (
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       resetn,
   // Request sources.
   input  wire logic [7:0] external_request_pins,
   input  wire logic [7:0] internal_requests,
   // Configuration.
   input  wire logic       master_edge_mode,
   input  wire logic       slave_edge_mode,
   input  wire logic [3:0] cascade_enable,
   input  wire logic [4:0] master_vector_base,
   input  wire logic [4:0] slave_vector_base,
   // Core side.
   input  wire logic       irq_acknowledge_n,
   input  irq_pkg::ctl_cmd_t command,
   output logic            core_irq,
   output logic [7:0]      vector,
   output logic            vector_valid,
   output logic [2:0]      cascade_select,
   output logic            cascade_ack
);
   pic_if m ();
   pic_if s ();
   logic [7:0] ext_s1;
   logic [7:0] ext_s2;
   logic       ack_s1;
   logic       ack_s2;
   logic       ack_prev;
   logic       ack_pulse;
   logic [2:0] m_lowest;
   logic [2:0] s_lowest;
   logic       from_slave;
   logic       from_cascade;

   // Pins pass two flip-flops before use.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ext_s1 <= 8'h00;
         ext_s2 <= 8'h00;
         ack_s1 <= 1'b1;
         ack_s2 <= 1'b1;
         ack_prev <= 1'b1;
      end else begin
         ext_s1 <= external_request_pins;
         ext_s2 <= ext_s1;
         ack_s1 <= irq_acknowledge_n;
         ack_s2 <= ack_s1;
         ack_prev <= ack_s2;
      end
   end

   // External acknowledge decode is the partner's job.
   assign ack_pulse = ack_prev && !ack_s2;                   // [R10]

   // Slave takes the internal sources, master the pins but pin 2, whose master input carries the slave.
   assign s.req = internal_requests;                         // [R2]
   assign m.req = {ext_s2[7:3], s.irq, ext_s2[1:0]};          // [R1] [R2]
   assign m.edge_mode = master_edge_mode;
   assign s.edge_mode = slave_edge_mode;
   assign m.lowest = m_lowest;
   assign s.lowest = s_lowest;
   assign from_slave = (m.win == `IRQ_SLAVE_INPUT);
   assign from_cascade = (m.win < 3'(`IRQ_CASCADE_PINS)) &&
                         cascade_enable[m.win[1:0]] && !from_slave; // [R9]
   assign m.ack = ack_pulse;
   assign s.ack = ack_pulse && from_slave && m.irq;
   assign m.eoi = (command == irq_pkg::cmd_eoi);
   assign s.eoi = m.eoi && (m.in_service[`IRQ_SLAVE_INPUT]);
   assign core_irq = m.irq;                                  // [R6]

   pic_core u_master (.clk(clk), .resetn(resetn), .p(m.pic));
   pic_core u_slave  (.clk(clk), .resetn(resetn), .p(s.pic));

   always_ff @(posedge clk) begin
      if (!resetn) begin
         m_lowest       <= `IRQ_LOWEST_RST;                  // [R7]
         s_lowest       <= `IRQ_LOWEST_RST;
         vector         <= 8'h00;
         vector_valid   <= 1'b0;
         cascade_select <= 3'h0;
         cascade_ack    <= 1'b0;
      end else begin
         vector_valid <= ack_pulse && m.irq;
         cascade_ack  <= ack_pulse && m.irq && from_cascade;
         if (ack_pulse && m.irq) begin
            cascade_select <= m.win;
            vector <= from_slave ? {slave_vector_base, s.win}
                                 : {master_vector_base, m.win}; // [R11]
         end
         // Rotation makes the current winner lowest.
         if (command == irq_pkg::cmd_rotate) begin
            m_lowest <= m.win;                               // [R8]
            s_lowest <= s.win;
         end
      end
   end
endmodule : irq_control_unit

// >>> pkg/irq_params.svh
// Purpose: Constants for the cascaded interrupt control unit.
// Assumes: Included by its bare name from the design files.
// Notes:   Behaviour
// Behaviour
// R1: Master and slave controllers joined in cascade.
// R2: Eight external and eight internal request sources; pin 2 is unused, so seven external pins reach the master.
// R3: Pending register bit set on each request.
// R4: Level or rising-edge sensing per controller.
// R5: Resolver picks highest priority per mode.
// R6: Resolver drives single interrupt line to core.
// R7: Reset order: input zero highest, seven lowest.
// R8: Software may rotate the priority order.
// R9: Low four external pins may be cascade inputs; master input 2 carries the slave, so only pins 0, 1 and 3 can.
// R10: External logic decodes acknowledge from bus status.
// R11: Acknowledge clears pending, sets in-service; EOI clears.
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH
`define IRQ_SLAVE_INPUT      3'h2
`define IRQ_CASCADE_PINS     4
`define IRQ_MASTER_BASE_RST  5'h08
`define IRQ_SLAVE_BASE_RST   5'h09
`define IRQ_LOWEST_RST       3'h7
`endif

// >>> pkg/irq_pkg.sv
// Purpose: Types shared by the interrupt control unit.
// Assumes: Nothing.
// Notes:   Holds types only.
package irq_pkg;
   typedef enum logic [1:0] {
      cmd_none      = 2'h0,
      cmd_eoi       = 2'h1,
      cmd_rotate    = 2'h2
   } ctl_cmd_t;
endpackage : irq_pkg

// >>> pkg/pic_if.sv
// Purpose: Links one controller module to the unit around it.
// Assumes: One clock domain.
// Notes:   The unit drives the ctl side.
interface pic_if;
   logic [7:0] req;
   logic       edge_mode;
   logic [2:0] lowest;
   logic       ack;
   logic       eoi;
   logic       irq;
   logic [2:0] win;
   logic [7:0] pending;
   logic [7:0] in_service;
   modport pic (input req, edge_mode, lowest, ack, eoi,
                output irq, win, pending, in_service);
   modport ctl (output req, edge_mode, lowest, ack, eoi,
                input irq, win, pending, in_service);
endinterface : pic_if

// >>> logic/pic_core.sv
// Purpose: One eight-input priority interrupt controller.
// Assumes: Requests are synchronous to clk.
// Notes:   Priority rotates from the input after lowest.
`include "irq_params.svh"
module pic_core (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Link to the unit.
   pic_if.pic       p
);
   logic [7:0] prev;
   logic [7:0] pending;
   logic [7:0] in_service;
   logic [7:0] rise;
   logic [7:0] set_mask;
   logic [7:0] rot;
   logic [7:0] rot_svc;
   logic [2:0] first;
   logic [2:0] first_svc;
   logic [2:0] done_idx;
   logic       any;

   // Rotate a vector so the highest priority input sits in bit 0.
   function automatic logic [7:0] spin(input logic [7:0] v,
                                       input logic [2:0] lo);
      logic [15:0] d;
      d = {v, v} >> (3'(lo + 3'h1));
      return d[7:0];
   endfunction : spin

   // Index of the lowest set bit.
   function automatic logic [2:0] lsb(input logic [7:0] v);
      logic [2:0] r;
      r = 3'h7;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction : lsb

   assign rise     = p.req & ~prev;
   assign set_mask = p.edge_mode ? rise : p.req;            // [R4]
   assign rot      = spin(pending, p.lowest);                // [R7] [R8]
   assign rot_svc  = spin(in_service, p.lowest);
   assign first    = lsb(rot);
   assign first_svc = lsb(rot_svc);
   // A request wins only above any input already in service.
   assign any = (rot != 8'h00) &&
                ((rot_svc == 8'h00) || (first < first_svc));  // [R5]
   assign p.win = 3'(first + p.lowest + 3'h1);
   // Undo the rotation modulo eight so lowest 7 maps back unchanged.
   assign done_idx = 3'(first_svc + p.lowest + 3'h1);
   assign p.irq = any;                                       // [R6]
   assign p.pending    = pending;
   assign p.in_service = in_service;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         prev       <= 8'h00;
         pending    <= 8'h00;
         in_service <= 8'h00;
      end else begin
         prev <= p.req;
         // A new request beats the acknowledge clear.
         pending <= (pending & ~((p.ack && any) ? 8'(1) << p.win
                                                : 8'h00))
                    | set_mask;                              // [R3] [R11]
         if (p.ack && any) begin
            in_service <= in_service | (8'(1) << p.win);     // [R11]
         end else if (p.eoi) begin
            in_service <= in_service & ~(8'(1) << done_idx); // [R11]
         end
      end
   end
endmodule : pic_core

// >>> tb/irq_props.sv
// Purpose: Assertions on the unit's core side.
// Assumes: Bases and cascade enables stay fixed.
// Notes:   Bound to the unit below.
module irq_props (
   // Clock and reset.
   input wire logic       clk,
   input wire logic       resetn,
   // Watched ports.
   input wire logic [3:0] cascade_enable,
   input wire logic [4:0] master_vector_base,
   input wire logic [4:0] slave_vector_base,
   input wire logic       core_irq,
   input wire logic [7:0] vector,
   input wire logic       vector_valid,
   input wire logic [2:0] cascade_select,
   input wire logic       cascade_ack
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   wire casc_won = !cascade_select[2] && cascade_select != 3'h2
      && cascade_enable[cascade_select[1:0]];
   property p_valid; vector_valid |=> !vector_valid; endproperty
   a_valid: assert property (p_valid) else $error("valid long");
   property p_cpulse; cascade_ack |=> !cascade_ack; endproperty
   a_cpulse: assert property (p_cpulse) else $error("ack long");
   property p_hold; !$stable(vector) |-> vector_valid; endproperty
   a_hold: assert property (p_hold) else $error("vector moved");
   property p_rst;
      disable iff (1'b0) !resetn |=> !core_irq && !vector_valid;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_svec;
      vector_valid && cascade_select == 3'h2
      |-> vector[7:3] == slave_vector_base;
   endproperty
   a_svec: assert property (p_svec) else $error("slave vec");
   property p_mvec;
      vector_valid && cascade_select != 3'h2
      |-> vector == {master_vector_base, cascade_select};
   endproperty
   a_mvec: assert property (p_mvec) else $error("master vec");
   property p_cack; cascade_ack |-> casc_won; endproperty
   a_cack: assert property (p_cack) else $error("bad cascade");
   property p_cneed; vector_valid && casc_won |-> cascade_ack; endproperty
   a_cneed: assert property (p_cneed) else $error("no cascade");
endmodule : irq_props
bind irq_control_unit irq_props irq_props_inst (.*);

// >>> tb/core_model.sv
// Purpose: Processor core answering the interrupt line.
// Assumes: Outputs change 2 ns after the rising edge.
// Notes:   Re-acknowledges no sooner than 9 cycles later.
module core_model (
   // Clock.
   input  wire logic        clk,
   // Core side.
   input  wire logic        core_irq,
   input  wire logic        vector_valid,
   output logic             irq_acknowledge_n,
   output irq_pkg::ctl_cmd_t command
);
   timeunit 1ns;
   timeprecision 100ps;
   int gap = 0;
   // Set by the bench to ask for one rotate while a request is up.
   logic rot_req = 1'b0;
   initial begin
      irq_acknowledge_n = 1'b1;
      command = irq_pkg::cmd_none;
      forever begin
         @(posedge clk) #2;
         command = vector_valid ? irq_pkg::cmd_eoi : irq_pkg::cmd_none;
         if (!vector_valid && rot_req && core_irq) begin
            command = irq_pkg::cmd_rotate;
            rot_req = 1'b0;
         end
         irq_acknowledge_n = !(core_irq && gap == 0);
         gap = irq_acknowledge_n ? (gap > 0 ? gap - 1 : 0) : 8;
      end
   end
endmodule : core_model

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the interrupt unit.
// Assumes: Inputs change 2 ns after the rising edge.
// Notes:   The core model acknowledges and ends each interrupt.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic              clk = 1'b0;
   logic              resetn = 1'b0;
   logic [7:0]        external_request_pins = 8'h00;
   logic [7:0]        internal_requests = 8'h00;
   logic              master_edge_mode = 1'b1;
   logic              slave_edge_mode = 1'b1;
   logic [3:0]        cascade_enable = 4'h0;
   logic [4:0]        master_vector_base = 5'h04;
   logic [4:0]        slave_vector_base = 5'h06;
   logic              irq_acknowledge_n;
   irq_pkg::ctl_cmd_t command;
   logic              core_irq;
   logic [7:0]        vector;
   logic              vector_valid;
   logic [2:0]        cascade_select;
   logic              cascade_ack;
   int                n_fail = 0;
   int                n_checks = 0;
   int                cycles = 0;
   irq_control_unit irq_control_unit_inst (.*);
   core_model core_model_inst (.*);
   initial forever #12.5 clk = !clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %h %h", $time, got, exp);
      end
   endtask : chk
   task automatic next_vec(input logic [7:0] exp, input logic ca);
      int n;
      n = 0;
      while (vector_valid !== 1'b1 && n < 100) begin
         @(posedge clk) #2;
         n++;
      end
      chk(vector, exp);
      chk({7'h00, cascade_ack}, {7'h00, ca});
      @(posedge clk) #2;
   endtask : next_vec
   task automatic t_order;
      external_request_pins = 8'h81;
      internal_requests = 8'h20;
      next_vec(8'h20, 1'b0);
      next_vec(8'h35, 1'b0);
      next_vec(8'h27, 1'b0);
      external_request_pins = 8'h00;
      internal_requests = 8'h00;
      $display("order test done");
   endtask : t_order
   task automatic t_level;
      slave_edge_mode = 1'b0;
      internal_requests = 8'h10;
      next_vec(8'h34, 1'b0);
      next_vec(8'h34, 1'b0);
      internal_requests = 8'h00;
      repeat (30) @(posedge clk) #2;
      chk({7'h00, core_irq}, 8'h00);
      $display("level test done");
   endtask : t_level
   task automatic t_casc;
      cascade_enable = 4'h2;
      external_request_pins = 8'h02;
      next_vec(8'h21, 1'b1);
      external_request_pins = 8'h00;
      $display("cascade test done");
   endtask : t_casc
   task automatic t_rot;
      cascade_enable = 4'h0;
      core_model_inst.rot_req = 1'b1;
      external_request_pins = 8'h21;
      next_vec(8'h25, 1'b0);
      next_vec(8'h20, 1'b0);
      external_request_pins = 8'h00;
      $display("rotate test done");
   endtask : t_rot
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (20) @(posedge clk);
      #2 resetn = 1'b1;
      t_order();
      t_level();
      t_casc();
      t_rot();
      final_report();
   end
endmodule : testbench
